// ===== design/ipc_top.sv
// Two-level prioritized interrupt controller with register port and return stack.
`timescale 1ns/1ns
module ipc_top #(
  parameter int STACK_DEPTH = 31,
  parameter int NPERIPH     = 8
) (
  // Clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // Register port
  input  wire logic [ipc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ipc_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wrEn,
  input  wire logic                        rdEn,
  output logic      [ipc_pkg::DATA_W-1:0]  rdata,
  // Event sources
  input  wire logic                        timer0Ovf,
  input  wire logic                        ext0Pin,
  input  wire logic [3:0]                  portPins,
  input  wire logic [NPERIPH-1:0]          periphEvent,
  // Core sequencer
  input  wire logic                        instrBoundary,
  input  wire logic                        retInstr,
  input  wire logic [ipc_pkg::PC_W-1:0]    returnAddr,
  output logic                             pcLoad,
  output logic      [ipc_pkg::PC_W-1:0]    pcValue
);
  import ipc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

  typedef struct packed {
    logic [DATA_W-1:0]                 main;
    logic [DATA_W-1:0]                 edgePrio;
    logic [DATA_W-1:0]                 resetControlReg;
    logic [NPERIPH-1:0]                pFlag;
    logic [NPERIPH-1:0]                pEnable;
    logic [NPERIPH-1:0]                pPrio;
    logic [1:0]                        ext0Sync;
    logic                              ext0Prev;
    logic [3:0]                        portS1;
    logic [3:0]                        portS2;
    logic [3:0]                        portLatch;
    logic                              hiActive;
    logic                              loActive;
    logic [SP_W-1:0]                   sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
    logic                              pcLoad;
    logic [PC_W-1:0]                   pcValue;
    logic [DATA_W-1:0]                 rdata;
  } ipc_state_t;

  ipc_state_t s;
  ipc_state_t next_s;

  // ----------------------------------------------------------------
  // Request evaluation
  // ----------------------------------------------------------------
  function automatic logic anyHit(input logic [NPERIPH-1:0] f,
                                  input logic [NPERIPH-1:0] e,
                                  input logic [NPERIPH-1:0] m);
    anyHit = |(f & e & m);
  endfunction : anyHit

  function automatic logic [DATA_W-1:0] widen(input logic [NPERIPH-1:0] v);
    widen = DATA_W'(v);
  endfunction : widen

  logic                priorityFeatureEnable;
  logic                highLevelGlobalEnable;
  logic                lowLevelGlobalEnable;
  logic                ext0Edge;
  logic [NPERIPH-1:0]  coreFlag;
  logic [NPERIPH-1:0]  coreEn;
  logic [NPERIPH-1:0]  corePrio;
  logic [NPERIPH-1:0]  allOnes;
  logic                compatPend;
  logic                hiPend;
  logic                loPend;
  logic                takeHi;
  logic                takeLo;

  assign allOnes               = '1;
  assign priorityFeatureEnable = s.resetControlReg[B_PRIO_FEAT];
  assign highLevelGlobalEnable = s.main[B_HIGH_GIE];
  assign lowLevelGlobalEnable  = s.main[B_LOW_GIE];
  // External 0 always sits at the high level; only timer0 and port carry a priority bit.
  assign coreFlag = NPERIPH'({s.main[B_T0_FLAG], s.main[B_EXT0_FLAG], s.main[B_PORT_FLAG]});
  assign coreEn   = NPERIPH'({s.main[B_T0_ENABLE], s.main[B_EXT0_EN], s.main[B_PORT_EN]});
  assign corePrio = NPERIPH'({s.edgePrio[B_T0_PRIO], 1'b1, s.edgePrio[B_PORT_PRIO]});
  // Only the synchronised copy is compared with its delayed self.
  assign ext0Edge = s.edgePrio[B_EXT0_EDGE] ? (s.ext0Sync[1] & ~s.ext0Prev)
                                            : (~s.ext0Sync[1] & s.ext0Prev);

  // Priority bits ignored; the peripheral group has its own gate.
  assign compatPend = highLevelGlobalEnable &
                      (anyHit(coreFlag, coreEn, allOnes) |
                       (lowLevelGlobalEnable & anyHit(s.pFlag, s.pEnable, allOnes)));
  // High level ignores any low routine in progress, so it preempts it.
  assign hiPend = priorityFeatureEnable
                ? highLevelGlobalEnable & (anyHit(coreFlag, coreEn, corePrio) |
                                           anyHit(s.pFlag, s.pEnable, s.pPrio))
                : compatPend;
  // Low level waits while a high routine runs.
  assign loPend = priorityFeatureEnable & lowLevelGlobalEnable & ~s.hiActive &
                  (anyHit(coreFlag, coreEn, ~corePrio) |
                   anyHit(s.pFlag, s.pEnable, ~s.pPrio));
  // Return has precedence when the core issues it at a boundary in the same cycle.
  assign takeHi = ce & instrBoundary & ~retInstr & hiPend;
  assign takeLo = ce & instrBoundary & ~retInstr & ~hiPend & loPend;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.pcLoad = 1'b0;
    if (ce) begin
      // Pins pass two flops before any logic looks at them.
      next_s.ext0Sync = {s.ext0Sync[0], ext0Pin};
      next_s.ext0Prev = s.ext0Sync[1];
      next_s.portS1   = portPins;
      next_s.portS2   = s.portS1;
      next_s.rdata    = ZERO_BYTE;
      if (wrEn) begin
        case (addr)
          REG_INTERRUPT_CONTROL_MAIN: next_s.main            = wdata;
          REG_EDGE_PRIORITY:          next_s.edgePrio        = wdata & EDGE_RST;
          REG_RESET_CONTROL:          next_s.resetControlReg = wdata & 8'h80;
          REG_PERIPH_FLAG:            next_s.pFlag           = wdata[NPERIPH-1:0];
          REG_PERIPH_ENABLE:          next_s.pEnable         = wdata[NPERIPH-1:0];
          REG_PERIPH_PRIORITY:        next_s.pPrio           = wdata[NPERIPH-1:0];
          default:                    next_s.main            = s.main;
        endcase
      end
      if (rdEn) begin
        case (addr)
          REG_INTERRUPT_CONTROL_MAIN: next_s.rdata = s.main;
          REG_EDGE_PRIORITY:          next_s.rdata = s.edgePrio;
          REG_RESET_CONTROL:          next_s.rdata = s.resetControlReg;
          REG_PERIPH_FLAG:            next_s.rdata = widen(s.pFlag);
          REG_PERIPH_ENABLE:          next_s.rdata = widen(s.pEnable);
          REG_PERIPH_PRIORITY:        next_s.rdata = widen(s.pPrio);
          REG_PORT_READ: begin
            next_s.rdata     = {s.portS2, 4'h0};
            next_s.portLatch = s.portS2;
          end
          REG_SERVICE_STATUS: next_s.rdata = {6'h00, s.hiActive, s.loActive};
          default:            next_s.rdata = ZERO_BYTE;
        endcase
      end
      // Hardware sets come after the write, so a set beats a clear.
      if (timer0Ovf) begin
        next_s.main[B_T0_FLAG] = 1'b1;
      end
      if (ext0Edge) begin
        next_s.main[B_EXT0_FLAG] = 1'b1;
      end
      if (s.portS2 != s.portLatch) begin
        next_s.main[B_PORT_FLAG] = 1'b1;
      end
      next_s.pFlag = next_s.pFlag | periphEvent;
      if (ce && retInstr) begin
        // Flags left set here retrigger at once; software must clear them first.
        if (s.sp != '0) begin
          next_s.sp      = s.sp - SP_ONE;
          next_s.pcValue = s.stack[s.sp - SP_ONE];
          next_s.pcLoad  = 1'b1;
        end
        if (priorityFeatureEnable && !s.hiActive && s.loActive) begin
          next_s.main[B_LOW_GIE] = 1'b1;
          next_s.loActive        = 1'b0;
        end else begin
          next_s.main[B_HIGH_GIE] = 1'b1;
          next_s.hiActive         = 1'b0;
        end
      end else if (takeHi || takeLo) begin
        // A full stack drops the push; the vector is still taken.
        if (s.sp != SP_FULL) begin
          next_s.stack[s.sp] = returnAddr;
          next_s.sp          = s.sp + SP_ONE;
        end
        next_s.pcLoad = 1'b1;
        if (takeHi) begin
          next_s.pcValue          = VEC_HIGH;
          next_s.main[B_HIGH_GIE] = 1'b0;
          next_s.hiActive         = 1'b1;
        end else begin
          next_s.pcValue         = VEC_LOW;
          next_s.main[B_LOW_GIE] = 1'b0;
          next_s.loActive        = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      next_s_reset();
    end else begin
      s <= next_s;
    end
  end

  task automatic next_s_reset();
    s                 <= '0;
    s.main            <= MAIN_RST;
    s.edgePrio        <= EDGE_RST;
    s.resetControlReg <= RESET_RST;
  endtask : next_s_reset

  assign rdata   = s.rdata;
  assign pcLoad  = s.pcLoad;
  assign pcValue = s.pcValue;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  hi_vector_a: assert property (takeHi |=> pcLoad && pcValue == VEC_HIGH)
    else $error("high request did not vector to the high address");
  lo_vector_a: assert property (takeLo |=> pcLoad && pcValue == VEC_LOW)
    else $error("low request did not vector to the low address");
  compat_vector_a: assert property ($rose(pcLoad) && !$past(priorityFeatureEnable)
                                    && !$past(retInstr) |-> pcValue == VEC_HIGH)
    else $error("compatibility accept used a vector other than the high one");
  enable_clear_a: assert property (takeHi |=> !s.main[B_HIGH_GIE] && s.hiActive)
    else $error("accepting a high request left its global enable set");
  lo_holdoff_a: assert property (s.hiActive && priorityFeatureEnable |-> !takeLo)
    else $error("low request taken during high service");
  return_enable_a: assert property (ce && retInstr && !priorityFeatureEnable
                                    |=> s.main[B_HIGH_GIE] && !s.hiActive)
    else $error("return did not restore the global enable");
  flag_set_a: assert property (ce && timer0Ovf |=> s.main[B_T0_FLAG])
    else $error("timer0 overflow flag lost");
  ext_flag_a: assert property (ce && ext0Edge |=> s.main[B_EXT0_FLAG])
    else $error("external 0 edge did not set its flag");
  port_flag_a: assert property (ce && s.portS2 != s.portLatch |=> s.main[B_PORT_FLAG])
    else $error("port mismatch did not keep the flag set");
  push_a: assert property ((takeHi || takeLo) && s.sp != SP_FULL
                           |=> s.sp == $past(s.sp) + SP_ONE)
    else $error("accept did not push the return address");
  reset_main_a: assert property ($past(rst) |-> s.main == MAIN_RST)
    else $error("main control register not cleared by reset");

  // ----------------------------------------------------------------
  // Checks on the priority levels
  // ----------------------------------------------------------------
  lo_enable_a: assert property (takeLo |=> !s.main[B_LOW_GIE] && s.loActive)
    else $error("accepting a low request left its global enable set");
  lo_return_a: assert property (ce && retInstr && priorityFeatureEnable && !s.hiActive
                                && s.loActive
                                |=> s.main[B_LOW_GIE] && !s.loActive)
    else $error("return from low service did not restore the low enable");
  hi_global_a: assert property (takeHi |-> highLevelGlobalEnable)
    else $error("high request taken with its global enable clear");
  lo_global_a: assert property (takeLo |-> lowLevelGlobalEnable && priorityFeatureEnable)
    else $error("low request taken without the low enable in priority mode");
  prio_ignored_a: assert property (!priorityFeatureEnable |-> !loPend)
    else $error("low level pending in compatibility mode");
  single_vec_a: assert property (takeLo |-> priorityFeatureEnable)
    else $error("low vector used in compatibility mode");
  preempt_a: assert property (s.loActive && !s.hiActive && takeHi
                              |=> s.hiActive && s.loActive)
    else $error("high request did not nest above the low routine");
  one_level_a: assert property (takeHi |-> !takeLo)
    else $error("both levels taken in one cycle");
  hi_first_a: assert property (ce && instrBoundary && !retInstr && hiPend |-> !takeLo)
    else $error("low request taken ahead of a pending high request");

  // ----------------------------------------------------------------
  // Checks on the flags and pins
  // ----------------------------------------------------------------
  // Pin to flag is fixed by the synchroniser, so the core sees it in bounded time.
  ext_latency_a: assert property (ce && $rose(s.ext0Sync[0]) && s.edgePrio[B_EXT0_EDGE]
                                  |-> ##2 s.main[B_EXT0_FLAG])
    else $error("external 0 flag later than the latency bound");
  edge_sense_a: assert property (ext0Edge && s.edgePrio[B_EXT0_EDGE] |-> s.ext0Sync[1])
    else $error("rising edge select fired on a falling edge");
  periph_flag_a: assert property (ce && periphEvent[0] |=> s.pFlag[0])
    else $error("peripheral event did not set its flag");
  port_read_a: assert property (ce && rdEn && addr == REG_PORT_READ
                                |=> s.portLatch == $past(s.portS2))
    else $error("port read did not end the mismatch");

  // ----------------------------------------------------------------
  // Checks on the stack, the bus and the freeze
  // ----------------------------------------------------------------
  pop_a: assert property (ce && retInstr && s.sp != '0
                          |=> pcLoad && s.sp == $past(s.sp) - SP_ONE)
    else $error("return did not pop the stack");
  stack_full_a: assert property ((takeHi || takeLo) && s.sp == SP_FULL
                                 |=> s.sp == SP_FULL)
    else $error("push past a full stack moved the pointer");
  rdata_idle_a: assert property (ce && !rdEn |=> rdata == ZERO_BYTE)
    else $error("read data stood beyond its cycle");
  reset_out_a: assert property ($past(rst) |-> !pcLoad && rdata == ZERO_BYTE
                                && pcValue == '0)
    else $error("outputs not cleared by reset");
  freeze_a: assert property (!ce |=> $stable(s.main) && $stable(s.sp))
    else $error("state moved while the clock enable was low");

  preempt_c:  cover property (s.loActive && takeHi);
  compat_c:   cover property (!priorityFeatureEnable && takeHi);
  return_c:   cover property (ce && retInstr && s.sp != '0);
  lo_entry_c: cover property (takeLo);
  holdoff_c:  cover property (s.hiActive && s.main[B_T0_FLAG] && s.main[B_LOW_GIE]);

endmodule : ipc_top

// ===== design/ipc_pkg.sv
// Register map, field positions, reset values and vectors of the interrupt controller.
package ipc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PC_W   = 21;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_INTERRUPT_CONTROL_MAIN = 3'h0;
  localparam logic [ADDR_W-1:0] REG_EDGE_PRIORITY          = 3'h1;
  localparam logic [ADDR_W-1:0] REG_RESET_CONTROL          = 3'h2;
  localparam logic [ADDR_W-1:0] REG_PERIPH_FLAG            = 3'h3;
  localparam logic [ADDR_W-1:0] REG_PERIPH_ENABLE          = 3'h4;
  localparam logic [ADDR_W-1:0] REG_PERIPH_PRIORITY        = 3'h5;
  localparam logic [ADDR_W-1:0] REG_PORT_READ              = 3'h6;
  localparam logic [ADDR_W-1:0] REG_SERVICE_STATUS         = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_HIGH_GIE   = 7;
  localparam int B_LOW_GIE    = 6;
  localparam int B_T0_ENABLE  = 5;
  localparam int B_EXT0_EN    = 4;
  localparam int B_PORT_EN    = 3;
  localparam int B_T0_FLAG    = 2;
  localparam int B_EXT0_FLAG  = 1;
  localparam int B_PORT_FLAG  = 0;
  localparam int B_EXT0_EDGE  = 6;
  localparam int B_T0_PRIO    = 2;
  localparam int B_PORT_PRIO  = 0;
  localparam int B_PRIO_FEAT  = 7;
  localparam int B_HI_ACTIVE  = 1;
  localparam int B_LO_ACTIVE  = 0;

  // ----------------------------------------------------------------
  // Reset values and vectors
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] MAIN_RST  = 8'h00;
  localparam logic [DATA_W-1:0] EDGE_RST  = 8'h45;
  localparam logic [DATA_W-1:0] RESET_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0]   VEC_HIGH  = 21'h000008;
  localparam logic [PC_W-1:0]   VEC_LOW   = 21'h000018;

endpackage : ipc_pkg

// ===== test/ipc_core_model.sv
// Core sequencer stand-in that makes instruction boundaries and return pulses.
`timescale 1ns/1ns
module ipc_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bench control
  input  wire logic slow,
  input  wire logic retReq,
  // Controller side
  output logic      instrBoundary,
  output logic      retInstr
);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A slow core meets a boundary only every other cycle, like two-cycle instructions.
  always_ff @(posedge clk) begin
    if (rst) begin
      instrBoundary <= 1'b0;
      retInstr      <= 1'b0;
    end else begin
      instrBoundary <= slow ? ~instrBoundary : 1'b1;
      retInstr      <= retReq;
    end
  end
endmodule : ipc_core_model

// ===== test/tb_top.sv
// Self-checking bench for the prioritized interrupt controller.
`timescale 1ns/1ns
module tb_top;
  import ipc_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wrEn = 1'b0;
  logic              rdEn = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              timer0Ovf = 1'b0;
  logic              ext0Pin = 1'b0;
  logic [3:0]        portPins = 4'h0;
  logic [7:0]        periphEvent = 8'h00;
  logic              instrBoundary;
  logic              retInstr;
  logic [PC_W-1:0]   returnAddr = '0;
  logic              pcLoad;
  logic [PC_W-1:0]   pcValue;
  logic              slow = 1'b0;
  logic              retReq = 1'b0;
  logic [PC_W-1:0]   stk[$];
  int                mismatches = 0;
  int                testsRun = 0;

  always #5 clk = ~clk;

  ipc_top #(.STACK_DEPTH(31), .NPERIPH(8)) dut_u (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wrEn(wrEn), .rdEn(rdEn),
    .rdata(rdata), .timer0Ovf(timer0Ovf), .ext0Pin(ext0Pin), .portPins(portPins),
    .periphEvent(periphEvent), .instrBoundary(instrBoundary), .retInstr(retInstr),
    .returnAddr(returnAddr), .pcLoad(pcLoad), .pcValue(pcValue)
  );

  ipc_core_model core_u (
    .clk(clk), .rst(rst), .slow(slow), .retReq(retReq),
    .instrBoundary(instrBoundary), .retInstr(retInstr)
  );

  // ----------------------------------------------------------------
  // Bench tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp,
                       input string what);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wrEn  <= 1'b1;
    @(posedge clk);
    wrEn  <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    check({13'h0000, rdata}, {13'h0000, e}, "register read");
  endtask : rd

  task automatic pulseT0();
    @(posedge clk);
    timer0Ovf <= 1'b1;
    @(posedge clk);
    timer0Ovf <= 1'b0;
  endtask : pulseT0

  task automatic setRet();
    logic [PC_W-1:0] v;
    v = PC_W'($urandom);
    @(posedge clk);
    returnAddr <= v;
    stk.push_back(v);
  endtask : setRet

  task automatic waitVec(input logic [PC_W-1:0] e);
    int n;
    for (n = 0; n < 16 && pcLoad !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check({20'h00000, pcLoad}, 21'h000001, "vector load");
    check(pcValue, e, "program counter");
    if (pcLoad !== 1'b1) begin
      end_of_test();
    end
  endtask : waitVec

  task automatic doRet();
    @(posedge clk);
    retReq <= 1'b1;
    @(posedge clk);
    retReq <= 1'b0;
    waitVec(stk.pop_back());
  endtask : doRet

  task automatic noVec(input int cycles);
    repeat (cycles) begin
      @(posedge clk);
      #1;
      check({20'h00000, pcLoad}, 21'h000000, "unexpected vector");
    end
  endtask : noVec

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(65255));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    rd(REG_EDGE_PRIORITY, 8'h45);
    rd(REG_RESET_CONTROL, 8'h00);
    wr(REG_SERVICE_STATUS, 8'hFF);
    rd(REG_SERVICE_STATUS, 8'h00);
    // A frozen block takes no event.
    @(posedge clk) ce <= 1'b0;
    pulseT0();
    @(posedge clk) ce <= 1'b1;
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    // Flags rise with every enable off, so polling works.
    pulseT0();
    noVec(2);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h04);
    @(posedge clk) ext0Pin <= 1'b1;
    noVec(5);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h06);
    @(posedge clk) ext0Pin <= 1'b0;
    noVec(5);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    @(posedge clk) portPins <= 4'h5;
    noVec(5);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h01);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h01);
    rd(REG_PORT_READ, 8'h50);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    // Compatibility mode with a low-priority source still takes the single vector.
    wr(REG_EDGE_PRIORITY, 8'h41);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'hA0);
    setRet();
    pulseT0();
    waitVec(VEC_HIGH);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h24);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h20);
    doRet();
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'hA0);
    // Peripheral sources wait for the group gate in compatibility mode.
    wr(REG_PERIPH_ENABLE, 8'h01);
    rd(REG_PERIPH_ENABLE, 8'h01);
    @(posedge clk) periphEvent <= 8'h01;
    @(posedge clk) periphEvent <= 8'h00;
    noVec(4);
    rd(REG_PERIPH_FLAG, 8'h01);
    setRet();
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'hE0);
    waitVec(VEC_HIGH);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h60);
    wr(REG_PERIPH_FLAG, 8'h00);
    doRet();
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'hE0);
    wr(REG_PERIPH_ENABLE, 8'h00);
    // Priority mode: low entry, high preemption, low held off, nested returns.
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h00);
    wr(REG_RESET_CONTROL, 8'h80);
    rd(REG_RESET_CONTROL, 8'h80);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h68);
    slow <= 1'b1;
    setRet();
    pulseT0();
    waitVec(VEC_LOW);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h2C);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'hA8);
    setRet();
    @(posedge clk) portPins <= 4'hA;
    waitVec(VEC_HIGH);
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'h29);
    rd(REG_PORT_READ, 8'hA0);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h68);
    pulseT0();
    noVec(8);
    wr(REG_INTERRUPT_CONTROL_MAIN, 8'h28);
    doRet();
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'hA8);
    doRet();
    rd(REG_INTERRUPT_CONTROL_MAIN, 8'hE8);
    end_of_test();
  end
endmodule : tb_top
